/* File: shared/ddr_sio_consts.svh */
// Purpose: shared constants for the ddr sio sram port, both ends
// Assumes: the x36 variant is built; narrower variant figures kept beside it
// Notes: the link half-cycle count is derived from the link and system clock periods; read latencies are fixed edge counts
`ifndef DDR_SIO_CONSTS_SVH
`define DDR_SIO_CONSTS_SVH

// variant in use: x36, four 9-bit byte lanes, 19 address bits
`define ADDR_W 19
`define DATA_W 36
`define LANE_W 9
`define LANES 4
`define DEPTH (1 << `ADDR_W)

// other variants, kept for reference builds
`define ADDR_W_X8 21
`define ADDR_W_X9 21
`define ADDR_W_X18 20
`define NIB_LANE_W 4
`define NIB_LANES 2

// burst: two words per transaction
`define BURST_LEN 2

// read latency in output clock edges after the capturing input rise
`define LAT_DLL_ON 3
`define LAT_DLL_OFF 2
`define SLOTS 4

// link clock made by the controller from mclk
`define MCLK_PERIOD_NS 20
`define LINK_PERIOD_NS 160
`define LINK_HALF_CYC ((`LINK_PERIOD_NS / `MCLK_PERIOD_NS) / 2)

// reset value of the idle command pins
`define LD_IDLE 1'h1

`endif

/* File: shared/ddr_sio_pkg.sv */
// Purpose: types shared by the ddr sio sram port ends
// Assumes: ddr_sio_consts.svh supplies the widths
// Notes: holds types only, no numbers of its own
`include "ddr_sio_consts.svh"

package ddr_sio_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`LANES-1:0] mask_t;

    // one queued output beat of the read port
    typedef struct packed {
        logic valid;
        word_t data;
    } slot_t;

    // controller command sequencing
    typedef enum logic [1:0] {
        CTL_IDLE,
        CTL_WAIT_RISE,
        CTL_WAIT_FALL
    } ctl_state_t;
endpackage

/* File: shared/ddr_sio_link_if.sv */
// Purpose: pin bundle between the memory controller and the sram device
// Assumes: both ends run on their own mclk and sample these as async pins
// Notes: read_bus is driven at all times, zero while released; read_oe tells when it carries read data
`timescale 1ns/1ns
`default_nettype none
`include "ddr_sio_consts.svh"

interface ddr_sio_link_if;
    // clocks from the controller
    logic input_timing_p;
    logic input_timing_n;
    logic output_timing_p;
    logic output_timing_n;
    // command and write port
    logic bus_cycle_load_n;
    logic direction_sel;
    logic [`ADDR_W-1:0] word_pointer;
    logic [`DATA_W-1:0] write_bus;
    logic [`LANES-1:0] byte_write_sel_n;
    // static configuration
    logic dll_disable_n;
    logic single_clk_mode;
    // read port and echo clocks from the device
    logic [`DATA_W-1:0] read_bus;
    logic read_oe;
    logic echo_out_p;
    logic echo_out_n;

    modport device (
        input input_timing_p, input_timing_n, output_timing_p, output_timing_n,
        input bus_cycle_load_n, direction_sel, word_pointer, write_bus,
        input byte_write_sel_n, dll_disable_n, single_clk_mode,
        output read_bus, read_oe, echo_out_p, echo_out_n
    );

    modport ctrl (
        output input_timing_p, input_timing_n, output_timing_p, output_timing_n,
        output bus_cycle_load_n, direction_sel, word_pointer, write_bus,
        output byte_write_sel_n, dll_disable_n, single_clk_mode,
        input read_bus, read_oe, echo_out_p, echo_out_n
    );
endinterface

`default_nettype wire

/* File: hdl/ddr_sio_device.sv */
// Purpose: behavioural sram device end of the ddr sio port, on mclk
// Assumes: link clocks are slow against mclk; every pin passes two flops
// Notes: no software registers; the memory content has no reset
//
// Operation
// R01 - controller loads cycle with low load strobe
// R02 - each transaction moves exactly two words
// R03 - x8 nibble selects mask low/high nibbles
// R04 - deselected nibble leaves stored nibble unchanged
// R05 - mask sampled on same edge as data
// R06 - wider variants mask 9-bit lanes per select
// R07 - deselected byte lane keeps stored byte
// R08 - address sampled at input rise, shared bus
// R09 - address width follows variant, two arrays
// R10 - address ignored when port deselected
// R11 - read data on output clock rises
// R12 - read bus released when read port idle
// R13 - direction high reads, low writes
// R14 - output clock pair times read data
// R15 - accesses start at input clock rise
// R16 - negative input rise captures, drives word two
// R17 - read bus width matches variant
// R18 - write data sampled on both input rises
// R19 - dll off gives shorter older-style latency
// R20 - free-running echo clock follows output clock
// R21 - first write word at rise, second after
// R22 - fixed read latency per dll setting
`timescale 1ns/1ns
`default_nettype none
`include "ddr_sio_consts.svh"

module ddr_sio_device (
    // system
    input wire logic mclk,
    input wire logic sys_rst,
    // link pins
    ddr_sio_link_if.device link
);
    import ddr_sio_pkg::*;

    localparam int SW = 6 + `ADDR_W + `DATA_W + `LANES + 2;

    // pin sample, two flops deep
    logic [SW-1:0] pin_meta;
    logic [SW-1:0] pin_sync;
    logic [3:0] clk_prev;

    // synchronised pin fields
    logic s_kp;
    logic s_kn;
    logic s_cp;
    logic s_cn;
    logic s_ld_n;
    logic s_dir;
    addr_t s_addr;
    word_t s_wdata;
    mask_t s_bws_n;
    logic s_dll_n;
    logic s_single;

    // edge strobes
    logic kp_rise;
    logic kn_rise;
    logic out_p_rise;
    logic out_n_rise;

    // write sequencing state
    logic wr_second;
    addr_t wr_addr;
    logic next_wr_second;
    addr_t next_wr_addr;

    // read port state
    slot_t slots [0:`SLOTS-1];
    slot_t next_slots [0:`SLOTS-1];
    word_t read_bus;
    logic read_oe;
    logic echo_p;
    logic echo_n;
    word_t next_read_bus;
    logic next_read_oe;
    logic next_echo_p;

    // the two burst arrays, one per burst position
    word_t bank0 [0:`DEPTH-1]; // R09
    word_t bank1 [0:`DEPTH-1];

    // memory write port
    logic mem_we;
    logic mem_bank;
    addr_t mem_addr;
    word_t mem_old;
    word_t mem_new;

    // both stages register only; logic reads pin_sync alone
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
            clk_prev <= 4'h0;
        end else begin
            pin_meta <= {link.input_timing_p, link.input_timing_n,
                         link.output_timing_p, link.output_timing_n,
                         link.bus_cycle_load_n, link.direction_sel,
                         link.word_pointer, link.write_bus,
                         link.byte_write_sel_n, link.dll_disable_n,
                         link.single_clk_mode};
            pin_sync <= pin_meta;
            clk_prev <= pin_sync[SW-1 -: 4];
        end
    end

    assign {s_kp, s_kn, s_cp, s_cn, s_ld_n, s_dir, s_addr, s_wdata, s_bws_n,
            s_dll_n, s_single} = pin_sync;

    // edges of the link clocks as seen on mclk
    assign kp_rise = s_kp & ~clk_prev[3]; // R15
    assign kn_rise = s_kn & ~clk_prev[2]; // R16
    // single clock mode times the read port off the input pair
    assign out_p_rise = s_single ? kp_rise : (s_cp & ~clk_prev[1]); // R11 R14
    assign out_n_rise = s_single ? kn_rise : (s_cn & ~clk_prev[0]); // R11 R16

    // write sequencing: rise takes word one, the next negative rise word two
    always_comb begin
        next_wr_second = wr_second;
        next_wr_addr = wr_addr;
        mem_we = 1'h0;
        mem_bank = 1'h0;
        mem_addr = s_addr;
        if (kp_rise) begin
            next_wr_second = 1'h0;
            // address and direction only count under a low load strobe
            if (!s_ld_n && !s_dir) begin // R01 R10 R13
                next_wr_addr = s_addr; // R08
                next_wr_second = 1'h1;
                mem_we = 1'h1; // R18 R21
            end
        end else if (kn_rise && wr_second) begin
            mem_we = 1'h1; // R02 R18 R21
            mem_bank = 1'h1;
            mem_addr = wr_addr;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_second <= 1'h0;
            wr_addr <= '0;
        end else begin
            wr_second <= next_wr_second;
            wr_addr <= next_wr_addr;
        end
    end

    // lane merge: a high select keeps the stored lane
    assign mem_old = mem_bank ? bank1[mem_addr] : bank0[mem_addr];
    for (genvar i = 0; i < `LANES; i++) begin : g_lane
        // mask bit comes from the same sampled edge as the data
        assign mem_new[i*`LANE_W +: `LANE_W] = s_bws_n[i] ? // R03 R05 R06
            mem_old[i*`LANE_W +: `LANE_W] : // R04 R07
            s_wdata[i*`LANE_W +: `LANE_W];
    end

    // array write, no reset: content is undefined at power up
    always_ff @(posedge mclk) begin
        if (mem_we && !mem_bank) begin
            bank0[mem_addr] <= mem_new;
        end
        if (mem_we && mem_bank) begin
            bank1[mem_addr] <= mem_new;
        end
    end

    // read port: slots hold beats keyed by output edges still to come
    always_comb begin
        int lat;
        lat = s_dll_n ? `LAT_DLL_ON : `LAT_DLL_OFF; // R19 R22
        next_read_bus = read_bus;
        next_read_oe = read_oe;
        next_echo_p = echo_p;
        for (int j = 0; j < `SLOTS; j++) begin
            next_slots[j] = slots[j];
        end
        if (out_p_rise || out_n_rise) begin
            // each beat leaves on an output rise, then the queue shifts
            next_read_bus = slots[0].valid ? slots[0].data : '0; // R11 R17
            next_read_oe = slots[0].valid; // R12
            for (int j = 0; j < `SLOTS - 1; j++) begin
                next_slots[j] = slots[j+1];
            end
            next_slots[`SLOTS-1] = '0;
        end
        // echo follows the output pair and runs whether or not reads run
        if (out_p_rise) begin
            next_echo_p = 1'h1; // R20
        end else if (out_n_rise) begin
            next_echo_p = 1'h0; // R20
        end
        // read load: both burst words queued at fixed distances
        if (kp_rise && !s_ld_n && s_dir) begin // R10 R13
            next_slots[lat-1] = '{valid: 1'h1, data: bank0[s_addr]}; // R02 R22
            next_slots[lat] = '{valid: 1'h1, data: bank1[s_addr]}; // R02 R16
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int j = 0; j < `SLOTS; j++) begin
                slots[j] <= '0;
            end
            read_bus <= '0;
            read_oe <= 1'h0;
            echo_p <= 1'h0;
            echo_n <= 1'h1;
        end else begin
            for (int j = 0; j < `SLOTS; j++) begin
                slots[j] <= next_slots[j];
            end
            read_bus <= next_read_bus;
            read_oe <= next_read_oe;
            echo_p <= next_echo_p;
            echo_n <= ~next_echo_p;
        end
    end

    // pins straight from flops; complement echo kept in step
    assign link.read_bus = read_bus;
    assign link.read_oe = read_oe;
    assign link.echo_out_p = echo_p;
    assign link.echo_out_n = echo_n;
endmodule

`default_nettype wire

/* File: hdl/ddr_sio_ctrl.sv */
// Purpose: memory controller end of the ddr sio port, on mclk
// Assumes: one user request per link period; responses cannot stall
// Notes: makes the link clocks by dividing mclk; reads paired by echo edges
`timescale 1ns/1ns
`default_nettype none
`include "ddr_sio_consts.svh"

module ddr_sio_ctrl (
    // system
    input wire logic mclk,
    input wire logic sys_rst,
    // configuration
    input wire logic single_clk_mode,
    input wire logic dll_disable_n,
    // request
    input wire logic req_valid,
    input wire logic req_write,
    input wire ddr_sio_pkg::addr_t req_addr,
    input wire ddr_sio_pkg::word_t req_wdata0,
    input wire ddr_sio_pkg::word_t req_wdata1,
    input wire ddr_sio_pkg::mask_t req_mask0_n,
    input wire ddr_sio_pkg::mask_t req_mask1_n,
    output logic req_ready,
    // read response
    output logic rsp_valid,
    output ddr_sio_pkg::word_t rsp_data0,
    output ddr_sio_pkg::word_t rsp_data1,
    // link pins
    ddr_sio_link_if.ctrl link
);
    import ddr_sio_pkg::*;

    localparam logic [2:0] HALF_LAST = 3'(`LINK_HALF_CYC - 1);

    // clock divider and command state
    ctl_state_t state, next_state;
    logic [2:0] div_cnt, next_div_cnt;
    logic kclk, next_kclk;
    logic kclk_n, clk_out_p, clk_out_n;
    logic ld_n, next_ld_n;
    logic dir, next_dir;
    addr_t addr, next_addr;
    word_t wdata, next_wdata;
    mask_t bws_n, next_bws_n;
    logic held_write, next_held_write;
    word_t held_w1, next_held_w1;
    mask_t held_m1, next_held_m1;
    logic ready, next_ready;
    logic toggle;

    assign toggle = (div_cnt == HALF_LAST);

    // command issue lines up with the divider's rise and fall
    always_comb begin
        next_state = state;
        next_div_cnt = toggle ? 3'h0 : div_cnt + 3'h1;
        next_kclk = toggle ? ~kclk : kclk;
        next_ld_n = ld_n;
        next_dir = dir;
        next_addr = addr;
        next_wdata = wdata;
        next_bws_n = bws_n;
        next_held_write = held_write;
        next_held_w1 = held_w1;
        next_held_m1 = held_m1;
        next_ready = ready;
        unique case (state)
            CTL_IDLE: begin
                next_ready = 1'h1; // ready from the first edge after reset
                if (req_valid && ready) begin
                    next_held_write = req_write;
                    next_addr = req_addr;
                    next_wdata = req_wdata0;
                    next_bws_n = req_mask0_n;
                    next_held_w1 = req_wdata1;
                    next_held_m1 = req_mask1_n;
                    next_ready = 1'h0;
                    next_state = CTL_WAIT_RISE;
                end
            end
            CTL_WAIT_RISE: begin
                if (toggle && !kclk) begin
                    next_ld_n = 1'h0; // R01
                    next_dir = ~held_write; // R13
                    next_state = CTL_WAIT_FALL;
                end
            end
            CTL_WAIT_FALL: begin
                if (toggle && !kclk) begin
                    next_ld_n = `LD_IDLE;
                end
                if (toggle && kclk) begin
                    // second word and its mask change together
                    next_wdata = held_w1; // R02 R05 R21
                    next_bws_n = held_m1; // R05
                    next_ld_n = `LD_IDLE;
                    next_ready = 1'h1;
                    next_state = CTL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= CTL_IDLE;
            div_cnt <= 3'h0;
            kclk <= 1'h0;
            ld_n <= `LD_IDLE;
            dir <= 1'h1;
            addr <= '0;
            wdata <= '0;
            bws_n <= '1;
            held_write <= 1'h0;
            held_w1 <= '0;
            held_m1 <= '1;
            ready <= 1'h0;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            kclk <= next_kclk;
            ld_n <= next_ld_n;
            dir <= next_dir;
            addr <= next_addr;
            wdata <= next_wdata;
            bws_n <= next_bws_n;
            held_write <= next_held_write;
            held_w1 <= next_held_w1;
            held_m1 <= next_held_m1;
            ready <= next_ready;
        end
    end

    // configuration pins registered so every pin leaves a flop
    logic cfg_single, cfg_dll_n;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_single <= 1'h0;
            cfg_dll_n <= 1'h1;
            kclk_n <= 1'h1;
            clk_out_p <= 1'h0;
            clk_out_n <= 1'h1;
        end else begin
            cfg_single <= single_clk_mode;
            cfg_dll_n <= dll_disable_n;
            kclk_n <= ~next_kclk;
            clk_out_p <= single_clk_mode | next_kclk;
            clk_out_n <= single_clk_mode | ~next_kclk;
        end
    end

    assign req_ready = ready;
    assign link.input_timing_p = kclk;
    assign link.input_timing_n = kclk_n;
    // in single clock mode the output pair is parked high
    assign link.output_timing_p = clk_out_p;
    assign link.output_timing_n = clk_out_n;
    assign link.bus_cycle_load_n = ld_n;
    assign link.direction_sel = dir;
    assign link.word_pointer = addr;
    assign link.write_bus = wdata;
    assign link.byte_write_sel_n = bws_n;
    assign link.dll_disable_n = cfg_dll_n;
    assign link.single_clk_mode = cfg_single;

    // read capture: pins through two flops, beats taken on echo edges
    logic [`DATA_W+1:0] rd_meta, rd_sync;
    logic echo_prev;
    logic half, next_half;
    logic next_rsp_valid;
    word_t next_rsp_data0, next_rsp_data1;
    logic s_echo, s_oe;
    word_t s_q;

    assign {s_echo, s_oe, s_q} = rd_sync;

    always_comb begin
        next_half = half;
        next_rsp_valid = 1'h0;
        next_rsp_data0 = rsp_data0;
        next_rsp_data1 = rsp_data1;
        if (s_echo != echo_prev) begin
            if (!s_oe) begin
                next_half = 1'h0;
            end else if (!half) begin
                next_rsp_data0 = s_q; // R02
                next_half = 1'h1;
            end else begin
                next_rsp_data1 = s_q; // R02
                next_rsp_valid = 1'h1;
                next_half = 1'h0;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_meta <= '0;
            rd_sync <= '0;
            echo_prev <= 1'h0;
            half <= 1'h0;
            rsp_valid <= 1'h0;
            rsp_data0 <= '0;
            rsp_data1 <= '0;
        end else begin
            rd_meta <= {link.echo_out_p, link.read_oe, link.read_bus};
            rd_sync <= rd_meta;
            echo_prev <= s_echo;
            half <= next_half;
            rsp_valid <= next_rsp_valid;
            rsp_data0 <= next_rsp_data0;
            rsp_data1 <= next_rsp_data1;
        end
    end
endmodule

`default_nettype wire

/* File: tb/ddr_sio_link_assertions.sv */
// Purpose: concurrent checks on the ddr sio link pins
// Assumes: both ends on one mclk; the controller makes the link clocks
// Notes: read windows are wide enough for pin sync and either dll latency
`timescale 1ns/1ns
`default_nettype none
`include "ddr_sio_consts.svh"

module ddr_sio_link_assertions (
    // system
    input wire logic mclk,
    input wire logic sys_rst,
    // link clocks
    input wire logic input_timing_p,
    input wire logic input_timing_n,
    input wire logic output_timing_p,
    input wire logic output_timing_n,
    // command and write port
    input wire logic bus_cycle_load_n,
    input wire logic direction_sel,
    input wire logic [`ADDR_W-1:0] word_pointer,
    input wire logic [`DATA_W-1:0] write_bus,
    input wire logic [`LANES-1:0] byte_write_sel_n,
    // straps
    input wire logic dll_disable_n,
    input wire logic single_clk_mode,
    // read port
    input wire logic [`DATA_W-1:0] read_bus,
    input wire logic read_oe,
    input wire logic echo_out_p,
    input wire logic echo_out_n
);
    logic p_q;
    logic next_p_q;
    logic [5:0] since_rd;
    logic [5:0] next_since_rd;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // age of the last read load; saturates so a long idle never wraps
    always_comb begin
        next_p_q = input_timing_p;
        next_since_rd = (since_rd == 6'h3F) ? since_rd : since_rd + 6'h01;
        if (input_timing_p && !p_q && !bus_cycle_load_n && direction_sel) begin
            next_since_rd = 6'h00;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            p_q <= 1'h0;
            since_rd <= 6'h3F;
        end else begin
            p_q <= next_p_q;
            since_rd <= next_since_rd;
        end
    end

    sequence rd_load_s;
        $rose(input_timing_p) && !bus_cycle_load_n && direction_sel;
    endsequence

    sequence rd_burst_s;
        read_oe [*6];
    endsequence

    clk_half_a: assert property ($rose(input_timing_p) |->
        input_timing_p [*4] ##1 !input_timing_p)
        else $error("link clock high phase not four mclk cycles");
    clk_pair_a: assert property (input_timing_n == !input_timing_p)
        else $error("input clock pair not complementary");
    load_edge_a: assert property ($changed(bus_cycle_load_n) |-> $changed(input_timing_p))
        else $error("load strobe moved away from a link clock edge");
    park_out_a: assert property (single_clk_mode [*3] |->
        output_timing_p && output_timing_n)
        else $error("output clocks not parked in single clock mode");
    rd_release_a: assert property (!read_oe |-> read_bus == '0)
        else $error("read bus driven while released");
    echo_pair_a: assert property (echo_out_n == !echo_out_p)
        else $error("echo clocks not complementary");
    echo_follow_a: assert property ($rose(input_timing_p) |-> ##[1:5] echo_out_p)
        else $error("echo clock not following link clock");
    rd_latency_a: assert property (rd_load_s |-> ##[9:20] read_oe)
        else $error("read data not driven within latency window");
    rd_burst_a: assert property ($rose(read_oe) |-> rd_burst_s)
        else $error("read burst shorter than two beats");
    rd_cause_a: assert property ($rose(read_oe) |-> since_rd <= 6'h18)
        else $error("read bus driven without a recent read load");
endmodule

`default_nettype wire

/* File: tb/ddr_sio_sram_port_tb.sv */
// Purpose: end-to-end bench, controller and device joined by the link
// Assumes: x36 build; one request per link period
// Notes: expectations come from a lane-merging model of both banks
`timescale 1ns/1ns
`default_nettype none
`include "ddr_sio_consts.svh"

module ddr_sio_sram_port_tb;
    import ddr_sio_pkg::*;
    typedef struct {logic wr; addr_t a; word_t d0; word_t d1; mask_t m0; mask_t m1;} row_t;
    logic mclk, sys_rst, single_clk_mode, dll_disable_n, req_valid, req_write;
    logic req_ready, rsp_valid;
    addr_t req_addr;
    word_t req_wdata0, req_wdata1, rsp_data0, rsp_data1;
    mask_t req_mask0_n, req_mask1_n;
    int fails, samples_checked;
    word_t mem0[addr_t];
    word_t mem1[addr_t];
    word_t exp_q[$];
    row_t rows[9];

    ddr_sio_link_if link ();
    ddr_sio_ctrl ddr_sio_ctrl_i (.mclk(mclk), .sys_rst(sys_rst),
        .single_clk_mode(single_clk_mode), .dll_disable_n(dll_disable_n),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata0(req_wdata0), .req_wdata1(req_wdata1), .req_mask0_n(req_mask0_n),
        .req_mask1_n(req_mask1_n), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data0(rsp_data0), .rsp_data1(rsp_data1), .link(link));
    ddr_sio_device ddr_sio_device_i (.mclk(mclk), .sys_rst(sys_rst), .link(link));
    ddr_sio_link_assertions ddr_sio_link_assertions_i (.mclk(mclk), .sys_rst(sys_rst),
        .input_timing_p(link.input_timing_p), .input_timing_n(link.input_timing_n),
        .output_timing_p(link.output_timing_p), .output_timing_n(link.output_timing_n),
        .bus_cycle_load_n(link.bus_cycle_load_n), .direction_sel(link.direction_sel),
        .word_pointer(link.word_pointer), .write_bus(link.write_bus),
        .byte_write_sel_n(link.byte_write_sel_n), .dll_disable_n(link.dll_disable_n),
        .single_clk_mode(link.single_clk_mode), .read_bus(link.read_bus),
        .read_oe(link.read_oe), .echo_out_p(link.echo_out_p), .echo_out_n(link.echo_out_n));

    task automatic check(input string what, input word_t seen, input word_t exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a low select writes its lane, a high one keeps the stored lane
    function automatic word_t merge(input word_t old, input word_t nw, input mask_t m_n);
        merge = old;
        for (int i = 0; i < `LANES; i++) begin
            if (!m_n[i]) merge[i*`LANE_W +: `LANE_W] = nw[i*`LANE_W +: `LANE_W];
        end
    endfunction

    // hand one request over, then watch it cross the link pins
    task automatic issue(input row_t r);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 64);
        @(posedge mclk);
        req_valid <= 1'h1;
        req_write <= r.wr;
        req_addr <= r.a;
        req_wdata0 <= r.d0;
        req_wdata1 <= r.d1;
        req_mask0_n <= r.m0;
        req_mask1_n <= r.m1;
        @(posedge mclk);
        req_valid <= 1'h0;
        if (r.wr) begin
            mem0[r.a] = merge(mem0[r.a], r.d0, r.m0);
            mem1[r.a] = merge(mem1[r.a], r.d1, r.m1);
        end else begin
            exp_q.push_back(mem0[r.a]);
            exp_q.push_back(mem1[r.a]);
        end
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (link.bus_cycle_load_n !== 1'b0 && n < 16);
        check("word_pointer", link.word_pointer, r.a);
        check("direction_sel", link.direction_sel, !r.wr);
        if (r.wr) begin
            check("write word0", link.write_bus, r.d0);
            check("write mask0", link.byte_write_sel_n, r.m0);
            n = 0;
            while (link.input_timing_p !== 1'b0 && n < 16) begin
                @(negedge mclk);
                n++;
            end
            check("write word1", link.write_bus, r.d1);
            check("write mask1", link.byte_write_sel_n, r.m1);
        end
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        check("reads drained", {35'h0, exp_q.size() == 0}, 36'h1);
    endtask

    // every response pairs with the two oldest expected words
    always @(negedge mclk) begin
        if (rsp_valid === 1'b1) begin
            check("rsp_data0", rsp_data0, exp_q.pop_front());
            check("rsp_data1", rsp_data1, exp_q.pop_front());
        end
    end

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // the whole run needs a few hundred cycles; this is ample margin
    initial begin
        #200000;
        fails++;
        results();
    end

    initial begin
        sys_rst = 1'h1;
        single_clk_mode = 1'h0;
        dll_disable_n = 1'h1;
        req_valid = 1'h0;
        req_write = 1'h0;
        req_addr = '0;
        req_wdata0 = '0;
        req_wdata1 = '0;
        req_mask0_n = 4'hF;
        req_mask1_n = 4'hF;
        // full writes come first so no kept lane is ever unknown
        rows = '{'{1'h1, 19'h00000, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0},
                 '{1'h0, 19'h00000, '0, '0, 4'hF, 4'hF},
                 '{1'h1, 19'h7FFFF, 36'hAAAAAAAAA, 36'h555555555, 4'h0, 4'h0},
                 '{1'h1, 19'h00000, 36'h000000000, 36'hFFFFFFFFF, 4'hA, 4'h5},
                 '{1'h1, 19'h7FFFF, 36'h000000000, 36'h000000000, 4'hF, 4'hF},
                 '{1'h0, 19'h00000, '0, '0, 4'hF, 4'hF},
                 '{1'h0, 19'h7FFFF, '0, '0, 4'hF, 4'hF},
                 '{1'h1, 19'h00000, 36'h0F0F0F0F0, 36'h3C3C3C3C3, 4'hE, 4'hD},
                 '{1'h0, 19'h00000, '0, '0, 4'hF, 4'hF}};
        repeat (12) @(negedge mclk);
        check("ready in reset", req_ready, 1'h0);
        check("read_oe in reset", link.read_oe, 1'h0);
        check("load in reset", link.bus_cycle_load_n, 1'h1);
        @(posedge mclk);
        sys_rst <= 1'h0;
        // dll on, dll off, then single clock mode
        for (int m = 0; m < 3; m++) begin
            @(posedge mclk);
            dll_disable_n <= (m != 1);
            single_clk_mode <= (m == 2);
            repeat (16) @(posedge mclk);
            foreach (rows[i]) begin
                issue(rows[i]);
            end
            drain();
        end
        // reset in mid-run must leave the array content in place
        @(posedge mclk);
        sys_rst <= 1'h1;
        repeat (3) @(negedge mclk);
        check("read_oe in reset", link.read_oe, 1'h0);
        @(posedge mclk);
        sys_rst <= 1'h0;
        issue(rows[8]);
        drain();
        results();
    end
endmodule

`default_nettype wire
